// ===== rtl/ebcs_params.svh
// constants for the external bus card slot multiplexer
`ifndef EBCS_PARAMS_SVH
`define EBCS_PARAMS_SVH
`define EBCS_SPACE_CS4     4'h5
`define EBCS_SPACE_CS5     4'h6
`define EBCS_SPACE_MSB     31
`define EBCS_SPACE_LSB     28
`define EBCS_MODE_MSB      23
`define EBCS_MODE_LSB      21
`define EBCS_REG_BIT       22
`define EBCS_RNW_BIT       25
`define EBCS_MODE_ATTR     3'h0
`define EBCS_MODE_COMMON   3'h2
`define EBCS_MODE_IO       3'h4
`define EBCS_MODE_IDE      3'h6
`define EBCS_MODE_ALT_IDE  3'h7
`define EBCS_DBW_8         2'h0
`define EBCS_DBW_16        2'h1
`define EBCS_ADDR_W        26
`define EBCS_DATA_W        32
`define EBCS_PU_W          16
`define EBCS_FLOAT_DEF     4
`endif

// ===== rtl/ebcs_pkg.sv
// types shared by the card slot multiplexer modules
package ebcs_pkg;
    typedef enum logic [2:0] {
        EBCS_ATTR,
        EBCS_COMMON,
        EBCS_IO,
        EBCS_IDE,
        EBCS_ALT_IDE,
        EBCS_NONE
    } ebcs_mode_t;
    typedef enum logic [1:0] {
        EBCS_OWN_IDLE,
        EBCS_OWN_SMC,
        EBCS_OWN_DRAM
    } ebcs_owner_t;
endpackage : ebcs_pkg

// ===== rtl/ebcs_card_if.sv
// decoded card access information between decoder and pin mux
`timescale 1ns/10ps
`default_nettype none
interface ebcs_card_if;
    import ebcs_pkg::*;
    logic       card_hit;
    ebcs_mode_t mode;
    logic       ce1_n;
    logic       ce2_n;
    logic       io_strobes;
    modport dec (output card_hit, output mode, output ce1_n, output ce2_n, output io_strobes);
    modport mux (input card_hit, input mode, input ce1_n, input ce2_n, input io_strobes);
endinterface : ebcs_card_if
`default_nettype wire

// ===== rtl/ebcs_card_decode.sv
// card mode decode and card enable generation
`timescale 1ns/10ps
`default_nettype none
`include "ebcs_params.svh"
module ebcs_card_decode
    import ebcs_pkg::*;
(
    // transfer from the static memory controller
    input  wire logic [31:0] xfer_addr,
    input  wire logic        chip_sel_four,
    input  wire logic        chip_sel_five,
    input  wire logic        lower_byte_sel,
    input  wire logic        upper_byte_sel,
    input  wire logic [1:0]  data_width_field,
    input  wire logic        byte_select_mode,
    // chip select assignment
    input  wire logic        assign_card_cs_four,
    input  wire logic        assign_card_cs_five,
    // decoded result
    ebcs_card_if.dec         card
);
    logic [3:0] space;
    logic [2:0] mbits;
    logic       hit4;
    logic       hit5;
    logic       cs_act_n;
    logic       wide;

    // space decode; cs low means the controller is running the cycle
    assign space = xfer_addr[`EBCS_SPACE_MSB:`EBCS_SPACE_LSB];
    assign mbits = xfer_addr[`EBCS_MODE_MSB:`EBCS_MODE_LSB];
    assign hit4 = assign_card_cs_four && !chip_sel_four && (space == `EBCS_SPACE_CS4); // [R1] [R2]
    assign hit5 = assign_card_cs_five && !chip_sel_five && (space == `EBCS_SPACE_CS5); // [R1] [R2]
    assign card.card_hit = hit4 || hit5;
    assign cs_act_n = hit4 ? chip_sel_four : chip_sel_five; // [R6]
    // byte selects only count when the controller runs byte select mode
    assign wide = (data_width_field == `EBCS_DBW_16) && byte_select_mode; // [R13]

    // mode table; undefined codes fall to none and leave the card idle
    always_comb begin
        card.mode = EBCS_NONE;
        if (card.card_hit) begin
            unique case (mbits) // [R3] [R5]
                `EBCS_MODE_ATTR:    card.mode = EBCS_ATTR;
                `EBCS_MODE_COMMON:  card.mode = EBCS_COMMON;
                `EBCS_MODE_IO:      card.mode = EBCS_IO;
                `EBCS_MODE_IDE:     card.mode = EBCS_IDE;
                `EBCS_MODE_ALT_IDE: card.mode = EBCS_ALT_IDE;
                default:            card.mode = EBCS_NONE;
            endcase
        end
    end

    // enables follow the chip select waveform, gated by mode and width
    always_comb begin
        card.ce1_n = 1'b1; // [R11]
        card.ce2_n = 1'b1;
        unique case (card.mode)
            EBCS_ATTR, EBCS_COMMON, EBCS_IO: begin
                if (wide) begin // [R7] [R8]
                    card.ce1_n = cs_act_n | lower_byte_sel;
                    card.ce2_n = cs_act_n | upper_byte_sel;
                end else begin // [R8]
                    card.ce1_n = cs_act_n;
                end
            end
            EBCS_IDE: card.ce1_n = cs_act_n; // [R9]
            EBCS_ALT_IDE: card.ce2_n = cs_act_n; // [R10]
            EBCS_NONE: card.ce1_n = 1'b1;
        endcase
    end
    // io and ide modes use the io strobe pair
    assign card.io_strobes = (card.mode == EBCS_IO) || (card.mode == EBCS_IDE)
                          || (card.mode == EBCS_ALT_IDE); // [R21]
endmodule : ebcs_card_decode
`default_nettype wire

// ===== rtl/ebcs_ext_bus_mux.sv
// external bus pin multiplexer with removable card slot support
// What this block does
// R1: card logic on assigned chip selects four/five
// R2: card spaces 0x5 and 0x6 regions
// R3: address bits 23:21 select card mode
// R4: address 22 is register select except IDE
// R5: five modes; no io16 or select handling
// R6: card enables follow active chip select timing
// R7: attribute mode enables follow byte selects; code does so only in 16-bit byte select, else enable one low, two high
// R8: common/io: byte selects, or odd byte
// R9: true IDE: enable one low, two high
// R10: alternate IDE: enable two low, one high
// R11: idle or unassigned: both enables high
// R12: software picks eight or sixteen bit width
// R13: byte selects valid only in byte select
// R14: share data, address, control among controllers
// R15: idle bus holds address and controls stable
// R16: honour data float time before handover
// R17: dram refresh takes the idle bus only with no static request
// R18: low data pullups on after reset; disable bit
// R19: software assigns pins to peripheral function
// R20: card selects and direction drive buffer only
// R21: io/IDE use io strobes, else memory
// R22: shared pins carry card signals only then
// R23: true IDE holds read strobe low, write high
// R24: card wait routed to controller wait input
`timescale 1ns/10ps
`default_nettype none
`include "ebcs_params.svh"
module ebcs_ext_bus_mux
    import ebcs_pkg::*;
#(
    parameter int ADDR_W  = `EBCS_ADDR_W,
    parameter int DATA_W  = `EBCS_DATA_W,
    parameter int FLOAT_W = `EBCS_FLOAT_DEF
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // chip configuration bits
    input  wire logic              assign_card_cs_four,
    input  wire logic              assign_card_cs_five,
    input  wire logic              data_pullup_disable,
    input  wire logic [1:0]        data_width_field,
    input  wire logic              byte_select_mode,
    // static memory controller side
    input  wire logic              smc_req,
    input  wire logic [31:0]       smc_addr,
    input  wire logic [DATA_W-1:0] smc_wdata,
    input  wire logic              smc_data_oe,
    input  wire logic [3:0]        smc_float_cycles,
    input  wire logic              chip_sel_four,
    input  wire logic              chip_sel_five,
    input  wire logic              smc_read_n,
    input  wire logic              smc_write_n,
    input  wire logic              lower_byte_sel,
    input  wire logic              upper_byte_sel,
    input  wire logic              smc_wr3_n,
    output logic                   smc_ext_wait,
    output logic [DATA_W-1:0]      smc_rdata,
    output logic                   smc_grant,
    // dram controller side
    input  wire logic              dram_req,
    input  wire logic [ADDR_W-1:0] dram_addr,
    input  wire logic [DATA_W-1:0] dram_wdata,
    input  wire logic              dram_data_oe,
    input  wire logic [3:0]        dram_float_cycles,
    output logic [DATA_W-1:0]      dram_rdata,
    output logic                   dram_grant,
    // external pins
    output logic [ADDR_W-1:0]      pin_addr,
    input  wire logic [DATA_W-1:0] pin_data_in,
    output logic [DATA_W-1:0]      pin_data_out,
    output logic                   pin_data_oe,
    output logic [`EBCS_PU_W-1:0]  pin_data_pullup,
    output logic                   card_buf_sel_zero,
    output logic                   card_buf_sel_one,
    output logic                   card_mem_read_strobe,
    output logic                   card_mem_write_strobe,
    output logic                   card_io_read_strobe,
    output logic                   card_io_write_strobe,
    output logic                   card_enable_one,
    output logic                   card_enable_two,
    input  wire logic              ext_wait_in
);
    ebcs_card_if card ();

    ebcs_card_decode u_dec (
        .xfer_addr           (smc_addr),
        .chip_sel_four       (chip_sel_four),
        .chip_sel_five       (chip_sel_five),
        .lower_byte_sel      (lower_byte_sel),
        .upper_byte_sel      (upper_byte_sel),
        .data_width_field    (data_width_field),
        .byte_select_mode    (byte_select_mode),
        .assign_card_cs_four (assign_card_cs_four),
        .assign_card_cs_five (assign_card_cs_five),
        .card                (card)
    );

    ////////////////////////////////////////////////////////////////////////////
    // data bus ownership and float time

    ebcs_owner_t         owner;
    ebcs_owner_t         next_owner;
    logic [FLOAT_W-1:0]  float_cnt;
    logic [FLOAT_W-1:0]  next_float_cnt;
    logic                float_busy;
    logic                want_smc;
    logic                want_dram;
    logic                owner_oe;

    // the two controllers own separate pins for refresh, so only data and address ownership
    // is arbitrated here; dram takes the idle bus only while no static request is pending
    assign float_busy = (float_cnt != '0);
    assign want_smc   = smc_req;
    assign want_dram  = dram_req && !smc_req; // [R17]
    // only the owner's output enable reaches the pins
    assign owner_oe   = (owner == EBCS_OWN_SMC) ? smc_data_oe :
                        (owner == EBCS_OWN_DRAM) ? dram_data_oe : 1'b0;

    // handover waits out the float time of the releasing controller
    always_comb begin
        next_owner     = owner;
        next_float_cnt = float_busy ? float_cnt - 1'b1 : float_cnt; // [R16]
        unique case (owner)
            EBCS_OWN_IDLE: begin
                if (!float_busy && want_smc) next_owner = EBCS_OWN_SMC; // [R14]
                else if (!float_busy && want_dram) next_owner = EBCS_OWN_DRAM;
            end
            // release loads this controller's float time
            EBCS_OWN_SMC: begin
                if (!smc_req) begin
                    next_owner     = EBCS_OWN_IDLE;
                    next_float_cnt = smc_float_cycles[FLOAT_W-1:0]; // [R16]
                end
            end
            EBCS_OWN_DRAM: begin
                if (!dram_req) begin
                    next_owner     = EBCS_OWN_IDLE;
                    next_float_cnt = dram_float_cycles[FLOAT_W-1:0]; // [R16]
                end
            end
        endcase
    end

    // ownership registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owner     <= EBCS_OWN_IDLE;
            float_cnt <= '0;
        end else begin
            owner     <= next_owner;
            float_cnt <= next_float_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address, data and strobe selection

    logic [ADDR_W-1:0] next_addr;
    logic              card_act;
    logic              rnw;
    logic              next_mem_rd;
    logic              next_mem_wr;
    logic              next_io_rd;
    logic              next_io_wr;

    // card pins only react while the static side owns the bus
    assign card_act = card.card_hit && (owner == EBCS_OWN_SMC);
    assign rnw      = smc_write_n;

    // address holds its last value while nobody drives the bus
    always_comb begin
        next_addr = pin_addr; // [R15]
        if (owner == EBCS_OWN_SMC) begin
            next_addr = smc_addr[ADDR_W-1:0]; // [R4] [R14]
            // top address bit carries read-not-write for the card
            if (card_act) begin
                next_addr[`EBCS_RNW_BIT] = rnw; // [R22]
            end
        end else if (owner == EBCS_OWN_DRAM) begin
            next_addr = dram_addr;
        end
    end

    // strobes: io pair in io and IDE modes, memory pair otherwise
    always_comb begin
        next_mem_rd = smc_read_n; // [R22]
        next_mem_wr = smc_write_n;
        next_io_rd  = upper_byte_sel;
        next_io_wr  = smc_wr3_n;
        if (owner != EBCS_OWN_SMC) begin
            next_mem_rd = 1'b1; // [R15]
            next_mem_wr = 1'b1;
            next_io_rd  = 1'b1;
            next_io_wr  = 1'b1;
        end else if (card_act && card.io_strobes) begin
            next_mem_rd = 1'b1; // [R21]
            next_mem_wr = 1'b1;
            next_io_rd  = smc_read_n;
            next_io_wr  = smc_write_n;
            // true IDE holds the output enable low
            if (card.mode != EBCS_ALT_IDE && card.mode != EBCS_IO) begin
                next_mem_rd = 1'b0; // [R23]
            end
        end else if (card_act) begin
            next_io_rd = 1'b1; // [R21]
            next_io_wr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wait input synchroniser; card wait stretches static accesses

    logic wait_meta;
    logic wait_sync;

    // two flops: the card wait is asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_meta <= 1'b0;
            wait_sync <= 1'b0;
        end else begin
            wait_meta <= ext_wait_in;
            wait_sync <= wait_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output registers; every pin comes from a flip-flop

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_addr              <= '0;
            pin_data_out          <= '0;
            pin_data_oe           <= 1'b0;
            pin_data_pullup       <= '1;
            card_buf_sel_zero     <= 1'b1;
            card_buf_sel_one      <= 1'b1;
            card_mem_read_strobe  <= 1'b1;
            card_mem_write_strobe <= 1'b1;
            card_io_read_strobe   <= 1'b1;
            card_io_write_strobe  <= 1'b1;
            card_enable_one       <= 1'b1;
            card_enable_two       <= 1'b1;
            smc_ext_wait          <= 1'b0;
            smc_rdata             <= '0;
            dram_rdata            <= '0;
            smc_grant             <= 1'b0;
            dram_grant            <= 1'b0;
        end else begin
            pin_addr              <= next_addr;
            pin_data_out          <= (owner == EBCS_OWN_DRAM) ? dram_wdata : smc_wdata;
            pin_data_oe           <= owner_oe && !float_busy; // [R16]
            pin_data_pullup       <= {`EBCS_PU_W{!data_pullup_disable}}; // [R18]
            // buffer controls only; never wired to the slot
            card_buf_sel_zero     <= chip_sel_four; // [R20]
            card_buf_sel_one      <= chip_sel_five; // [R20]
            card_mem_read_strobe  <= next_mem_rd;
            card_mem_write_strobe <= next_mem_wr;
            card_io_read_strobe   <= next_io_rd;
            card_io_write_strobe  <= next_io_wr;
            card_enable_one       <= card_act ? card.ce1_n : 1'b1; // [R11]
            card_enable_two       <= card_act ? card.ce2_n : 1'b1; // [R11]
            smc_ext_wait          <= card_act && wait_sync; // [R24]
            // read data captured every cycle; owners use it on grant
            smc_rdata             <= pin_data_in;
            dram_rdata            <= pin_data_in;
            smc_grant             <= (next_owner == EBCS_OWN_SMC);
            dram_grant            <= (next_owner == EBCS_OWN_DRAM);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // owner let go: idle with its float time loaded
    sequence s_released;
        (owner != EBCS_OWN_IDLE) ##1 (owner == EBCS_OWN_IDLE) && float_busy;
    endsequence

    // card wait seen in the first of three cycles of one access
    sequence s_card_wait;
        card_act && ext_wait_in ##1 card_act ##1 card_act;
    endsequence

    // float time
    a_float_no_drive: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        float_busy |=> !pin_data_oe) else $error("data driven during float time");

    a_release_float: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        s_released |-> ##[1:16] !float_busy) else $error("float time never ends");

    // idle bus and pullups
    a_idle_enables: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        card.mode == EBCS_NONE |-> card.ce1_n && card.ce2_n)
        else $error("decoded enable low with no card mode");

    a_idle_enables_high: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        !card_act |=> card_enable_one && card_enable_two) else $error("enable low when idle");

    a_idle_addr_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        (owner == EBCS_OWN_IDLE) |=> $stable(pin_addr)) else $error("address moved idle");

    a_idle_strobes: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        (owner == EBCS_OWN_IDLE) |=> card_mem_read_strobe && card_io_write_strobe)
        else $error("strobe active while idle");

    a_pullup_follow: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        1'b1 |=> pin_data_pullup == {`EBCS_PU_W{!$past(data_pullup_disable)}})
        else $error("pullup not following disable");

    // card pins per mode
    a_io_mode_strobes: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        card_act && card.mode == EBCS_IO |=> card_mem_read_strobe && card_mem_write_strobe)
        else $error("memory strobe in io mode");

    a_ide_read_low: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
        card_act && card.mode == EBCS_IDE |=> !card_mem_read_strobe && card_mem_write_strobe)
        else $error("ide strobes wrong");

    a_alt_ide_enables: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        card_act && card.mode == EBCS_ALT_IDE && !chip_sel_four |=> card_enable_one)
        else $error("alternate ide enable one low");

    // byte selects steer the enables in wide attribute access
    a_attr_byte_sel: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        card_act && card.mode == EBCS_ATTR && byte_select_mode
        && data_width_field == `EBCS_DBW_16 |=> card_enable_two == $past(upper_byte_sel)
        && card_enable_one == $past(lower_byte_sel)) else $error("enables miss byte selects");

    // wait and arbitration
    a_wait_route: assert property (@(posedge clk) disable iff (!rst_n) // [R24]
        s_card_wait |=> smc_ext_wait) else $error("card wait not forwarded");

    a_dram_yields: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        (owner == EBCS_OWN_IDLE) && !float_busy && smc_req |=> owner == EBCS_OWN_SMC)
        else $error("static request delayed");
endmodule : ebcs_ext_bus_mux
`default_nettype wire

// ===== verif/ebcs_card_slot_model.sv
// card slot model standing behind the bidirectional data buffer
`timescale 1ns/10ps
`default_nettype none
module ebcs_card_slot_model (
    // clock and bench control
    input  wire logic        clk,
    input  wire logic        wait_req,
    // card side of the buffer
    input  wire logic        card_enable_one,
    input  wire logic        card_enable_two,
    input  wire logic        card_mem_read_strobe,
    input  wire logic        card_io_read_strobe,
    input  wire logic [25:0] pin_addr,
    output logic [31:0]      pin_data_in,
    output logic             ext_wait_in
);
    ////////////////////////////////////////////////////////////
    logic sel;
    logic rd;
    // selected when either enable is low, reading on either read strobe
    assign sel = !card_enable_one || !card_enable_two;
    assign rd  = sel && (!card_mem_read_strobe || !card_io_read_strobe);
    // wait only while selected, as a real card would
    assign ext_wait_in = wait_req && sel;
    // released bus toggles so a stale value never looks like a good read
    initial pin_data_in = 32'h0000_0000;
    always @(posedge clk) begin
        if (rd) begin
            pin_data_in <= {16'ha5c3, 5'h00, pin_addr[10:0]};
        end else begin
            pin_data_in <= ~pin_data_in;
        end
    end
endmodule : ebcs_card_slot_model
`default_nettype wire

// ===== verif/test_ebcs_ext_bus_mux.sv
// self-checking bench for the external bus card slot multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "ebcs_params.svh"
module test_ebcs_ext_bus_mux;
    ////////////////////////////////////////////////////////////
    // design inputs
    logic        clk, rst_n, assign_card_cs_four, assign_card_cs_five;
    logic        data_pullup_disable, byte_select_mode, smc_req, smc_data_oe;
    logic        chip_sel_four, chip_sel_five, smc_read_n, smc_write_n, smc_wr3_n;
    logic        lower_byte_sel, upper_byte_sel, dram_req, wait_req, ext_wait_in;
    logic [1:0]  data_width_field;
    logic [31:0] smc_addr, smc_wdata, dram_wdata, pin_data_in;
    logic [3:0]  smc_float_cycles, dram_float_cycles;
    logic [25:0] dram_addr;
    logic [8:0]  ctl;
    // design outputs
    logic        smc_ext_wait, smc_grant, dram_grant, pin_data_oe, card_buf_sel_zero;
    logic        card_buf_sel_one, card_mem_read_strobe, card_mem_write_strobe;
    logic        card_io_read_strobe, card_io_write_strobe, card_enable_one, card_enable_two;
    logic [31:0] smc_rdata, dram_rdata, pin_data_out;
    logic [25:0] pin_addr;
    logic [15:0] pin_data_pullup;
    int          err_count, checks;
    // {mode, 16-bit width, upper sel, lower sel, read_n} per card transfer
    logic [6:0]  tbl [8] = '{7'b000_1_10_0, 7'b010_1_01_0, 7'b010_0_11_0, 7'b100_1_00_1,
                            7'b100_0_11_1, 7'b110_0_11_0, 7'b110_1_00_1, 7'b111_0_11_0};

    // one vector drives the static controller strobes
    assign {smc_req, chip_sel_five, chip_sel_four, smc_read_n, smc_write_n, smc_wr3_n,
            smc_data_oe, upper_byte_sel, lower_byte_sel} = ctl;

    ebcs_ext_bus_mux i_ebcs_ext_bus_mux (
        .clk, .rst_n, .assign_card_cs_four, .assign_card_cs_five, .data_pullup_disable,
        .data_width_field, .byte_select_mode, .smc_req, .smc_addr, .smc_wdata, .smc_data_oe,
        .smc_float_cycles, .chip_sel_four, .chip_sel_five, .smc_read_n, .smc_write_n,
        .lower_byte_sel, .upper_byte_sel, .smc_wr3_n, .smc_ext_wait, .smc_rdata, .smc_grant,
        .dram_req, .dram_addr, .dram_wdata, .dram_data_oe(1'b1), .dram_float_cycles,
        .dram_rdata, .dram_grant, .pin_addr, .pin_data_in, .pin_data_out, .pin_data_oe,
        .pin_data_pullup, .card_buf_sel_zero, .card_buf_sel_one, .card_mem_read_strobe,
        .card_mem_write_strobe, .card_io_read_strobe, .card_io_write_strobe,
        .card_enable_one, .card_enable_two, .ext_wait_in
    );

    ebcs_card_slot_model i_ebcs_card_slot_model (
        .clk, .wait_req, .card_enable_one, .card_enable_two, .card_mem_read_strobe,
        .card_io_read_strobe, .pin_addr, .pin_data_in, .ext_wait_in
    );

    // 250 MHz
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // one static transfer, held until the pins settle
    task automatic acc(input logic [31:0] a, input logic c4, c5, rd_n, ub, lb);
        @(posedge clk);
        ctl      <= {1'b1, c5, c4, rd_n, ~rd_n, ~rd_n, rd_n, ub, lb};
        smc_addr <= a;
        repeat (7) @(posedge clk);
        @(negedge clk);
    endtask : acc

    // release the bus and wait out the float time
    task automatic rel;
        @(posedge clk);
        ctl <= 9'h0fb;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : rel

    // expected {enable two, enable one, mem rd, mem wr, io rd, io wr}
    function automatic logic [5:0] exp_pins(input logic [2:0] m, input logic w16, rd, ub, lb);
        logic [1:0] bs;
        bs = w16 ? {ub, lb} : 2'b10;
        case (m)
            `EBCS_MODE_ATTR:   exp_pins = {ub, lb, rd, ~rd, 2'b11};
            `EBCS_MODE_COMMON: exp_pins = {bs, rd, ~rd, 2'b11};
            `EBCS_MODE_IO:     exp_pins = {bs, 2'b11, rd, ~rd};
            `EBCS_MODE_IDE:    exp_pins = {2'b10, 2'b01, rd, ~rd};
            default:           exp_pins = {2'b01, 2'b11, rd, ~rd};
        endcase
    endfunction : exp_pins

    ////////////////////////////////////////////////////////////
    initial begin
        logic [2:0]  m;
        logic        w16, ub, lb, rd;
        logic [31:0] a;
        logic [25:0] hold;
        clk = 1'b0;
        rst_n = 1'b0;
        ctl = 9'h0fb;
        smc_addr = 32'h0000_0000;
        smc_wdata = 32'h0000_0000;
        smc_float_cycles = 4'h3;
        dram_float_cycles = 4'h2;
        assign_card_cs_four = 1'b1;
        assign_card_cs_five = 1'b1;
        data_pullup_disable = 1'b0;
        data_width_field = `EBCS_DBW_16;
        byte_select_mode = 1'b1;
        dram_req = 1'b0;
        dram_addr = 26'h2a5_a5a5;
        dram_wdata = 32'hc0de_7531;
        wait_req = 1'b0;
        err_count = 0;
        checks = 0;
        @(negedge clk);
        chk(pin_data_pullup, 16'hffff);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // every card mode, both spaces and widths
        for (int i = 0; i < 8; i++) begin
            {m, w16, ub, lb, rd} = tbl[i];
            a = {i[0] ? `EBCS_SPACE_CS5 : `EBCS_SPACE_CS4, 4'h0, m, 18'h0, i[2:0]};
            @(posedge clk);
            data_width_field <= w16 ? `EBCS_DBW_16 : `EBCS_DBW_8;
            byte_select_mode <= w16;
            wait_req         <= (i == 3);
            smc_wdata        <= {8'h3c, 21'h0, i[2:0]};
            acc(a, i[0], ~i[0], rd, ub, lb);
            chk(smc_grant, 1'b1);
            chk({card_enable_two, card_enable_one, card_mem_read_strobe, card_mem_write_strobe,
                 card_io_read_strobe, card_io_write_strobe},
                exp_pins(m, w16, rd, ub, lb));
            chk(pin_addr, {~rd, a[24:0]});
            chk({card_buf_sel_one, card_buf_sel_zero}, {~i[0], i[0]});
            chk(smc_ext_wait, (i == 3));
            if (rd) begin
                chk({pin_data_oe, pin_data_out}, {1'b1, smc_wdata});
            end else begin
                chk(smc_rdata, {16'ha5c3, 5'h00, a[10:0]});
            end
            rel();
            chk({card_enable_two, card_enable_one}, 2'b11);
        end
        // unassigned space: plain bus use
        @(posedge clk);
        assign_card_cs_five <= 1'b0;
        acc(32'h6040_0010, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        chk({card_enable_two, card_enable_one, card_mem_read_strobe, card_mem_write_strobe,
             card_io_read_strobe, card_io_write_strobe}, 6'b11_0101);
        chk(pin_addr, 26'h040_0010);
        // dram handover waits out the float time
        acc(32'h5040_0004, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        @(posedge clk);
        ctl      <= 9'h0fb;
        dram_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk({dram_grant, pin_data_oe}, 2'b00);
        for (int n = 0; n < 20 && dram_grant !== 1'b1; n++) @(negedge clk);
        chk(dram_grant, 1'b1);
        repeat (2) @(negedge clk);
        chk({pin_addr, pin_data_oe, pin_data_out}, {dram_addr, 1'b1, dram_wdata});
        a = pin_data_in;
        @(negedge clk);
        chk(dram_rdata, a);
        // idle bus keeps address and controls still
        @(posedge clk);
        dram_req <= 1'b0;
        repeat (10) @(negedge clk);
        hold = pin_addr;
        repeat (5) @(negedge clk);
        chk(pin_addr, hold);
        chk({card_mem_read_strobe, card_mem_write_strobe, card_io_read_strobe,
             card_io_write_strobe, card_enable_two, card_enable_one}, 6'h3f);
        // pull-up disable bit
        chk(pin_data_pullup, 16'hffff);
        @(posedge clk);
        data_pullup_disable <= 1'b1;
        repeat (3) @(negedge clk);
        chk(pin_data_pullup, 16'h0000);
        final_report();
    end
endmodule : test_ebcs_ext_bus_mux
`default_nettype wire
